// *** hdl/bmc_device.sv ***
// Purpose: battery mode controller, device end
// Assumes: comparator, pll and wake inputs are asynchronous levels
// Notes:   32 kHz crystal clock is sampled as a level on the core clock
`include "bmc_cfg.svh"
`timescale 1ns/1ps
module bmc_device
	import bmc_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic       i_arst_n,
	input  wire logic       i_sys_above_3v0,
	input  wire logic       i_sys_above_2v8,
	input  wire logic       i_core_above_2v25,
	input  wire logic       i_core_above_2v0,
	input  wire logic       i_pll_locked,
	input  wire logic       i_crystal_clock_32k,
	input  wire logic       i_wake_timer,
	input  wire logic       i_pushbutton_wake,
	input  wire logic       i_wake_pin_a,
	input  wire logic       i_wake_pin_b,
	input  wire logic       i_wake_pin_c,
	input  wire logic       i_serial_rx,
	input  wire logic       i_optical_receive,
	bmc_if.dev              bus,
	output bmc_mode_t       o_mode,
	output logic            o_on_battery,
	output logic            o_pll_enable,
	output logic            o_display_enable,
	output logic            o_boost_enable,
	output logic            o_core_supply_enable,
	output logic [7:0]      o_clock_gen_config,
	output logic            o_ce_enable
);
	// ------------------------------------------------------------
	// input synchronisation
	// ------------------------------------------------------------
	logic [12:0] raw_in;
	logic [12:0] sin;
	assign raw_in = {i_sys_above_3v0, i_sys_above_2v8, i_core_above_2v25, i_core_above_2v0,
		i_pll_locked, i_crystal_clock_32k, i_wake_timer, i_pushbutton_wake, i_wake_pin_a,
		i_wake_pin_b, i_wake_pin_c, i_serial_rx, i_optical_receive};

	// supplies and pll read as good in reset, so release causes no false loss
	bmc_sync #(.W(13), .RST(13'h1F00)) u_sync (
		.i_mclk   (i_mclk),
		.i_arst_n (i_arst_n),
		.i_async  (raw_in),
		.o_sync   (sin)
	);

	logic sys_power_good;
	logic sys_present;
	logic core_ok;
	logic core_alive;
	logic pll_stable;
	logic xtal;
	logic [5:0] wake_now;
	assign sys_power_good = sin[12];
	assign sys_present    = sin[11];
	assign core_ok        = sin[10];
	assign core_alive     = sin[9];
	assign pll_stable     = sin[8];
	assign xtal           = sin[7];
	assign wake_now       = {sin[6:2], sin[1] | sin[0]}; // either receive pin

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	bmc_mode_t  mode;
	bmc_mode_t  next_mode;
	logic [2:0] power_status_field;
	logic [2:0] next_power_status_field;
	logic [5:0] wake_prev;
	logic [5:0] wake_cause;
	logic [5:0] next_wake_cause;
	logic       display_only_request;
	logic       sleep_request;
	logic       next_display_only_request;
	logic       next_sleep_request;
	logic [1:0] display_boost_select;
	logic [1:0] next_display_boost_select;
	logic [7:0] clock_gen_config;
	logic [7:0] next_clock_gen_config;
	logic       ce_enable;
	logic       next_ce_enable;
	logic       irq;
	logic       next_irq;
	logic       xtal_prev;
	logic [2:0] dying_count;
	logic [2:0] next_dying_count;
	logic       cpu_reset;
	logic       next_cpu_reset;
	logic       sleep_from_mission;
	logic       next_sleep_from_mission;

	function automatic logic wr_hit(input logic [15:0] a);
		wr_hit = bus.wr_en && (bus.wr_addr == a);
	endfunction

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		logic [5:0] wake_edge;
		logic       mission_ok;
		wake_edge  = wake_now & ~wake_prev;
		mission_ok = sys_power_good & pll_stable;
		next_mode                 = mode;
		next_irq                  = 1'b0;
		next_wake_cause           = wake_cause;
		next_display_only_request = display_only_request;
		next_sleep_request        = sleep_request;
		next_display_boost_select = display_boost_select;
		next_clock_gen_config     = clock_gen_config;
		next_ce_enable            = ce_enable;
		next_sleep_from_mission   = 1'b0;
		next_cpu_reset            = 1'b0;
		next_dying_count          = 3'h0;
		// control writes
		if (wr_hit(`BMC_ADDR_MODE_CTRL)) begin
			next_display_only_request = bus.wr_data[`BMC_BIT_DISP_ONLY];
			next_sleep_request        = bus.wr_data[`BMC_BIT_SLEEP];
		end
		if (wr_hit(`BMC_ADDR_DISP_BOOST)) begin
			next_display_boost_select = bus.wr_data[`BMC_BOOST_MSB:`BMC_BOOST_LSB];
		end
		if (wr_hit(`BMC_ADDR_CLOCK_GEN)) begin
			next_clock_gen_config = bus.wr_data;
		end
		if (wr_hit(`BMC_ADDR_CE_CTRL)) begin
			next_ce_enable = bus.wr_data[`BMC_BIT_CE_ENABLE];
		end
		case (mode)
			BMC_MISSION: begin
				next_display_only_request = 1'b0;           // refused, not kept
				if (!sys_power_good && !sys_present) begin
					next_mode = BMC_BROWNOUT;
					next_irq  = 1'b1;
				end else if (next_sleep_request) begin
					next_mode = BMC_SLEEP;
					next_sleep_from_mission = 1'b1;
				end
			end
			BMC_BROWNOUT: begin
				if (mission_ok) begin
					next_mode = BMC_MISSION;
					next_irq  = 1'b1;
				end else if (next_sleep_request) begin
					next_mode = BMC_SLEEP;
				end else if (next_display_only_request) begin
					next_mode = BMC_DISP_ONLY;
				end
			end
			default: begin
				if (mission_ok) begin
					next_mode = BMC_MISSION;
					next_irq  = 1'b1;
					next_display_only_request = 1'b0;
					next_sleep_request        = 1'b0;
				end else if (wake_edge != 6'h00 || sleep_from_mission) begin
					next_mode = BMC_BROWNOUT;
					next_wake_cause = wake_edge;
					next_display_only_request = 1'b0;
					next_sleep_request        = 1'b0;
					// wake restarts the cpu with reset settings
					next_clock_gen_config = `BMC_CLOCK_GEN_RESET;
					next_ce_enable        = 1'b0;
				end
			end
		endcase
		// status field
		if (sys_power_good) begin
			next_power_status_field = `BMC_VST_GOOD;
		end else if (sys_present && mode == BMC_MISSION) begin
			next_power_status_field = `BMC_VST_LOW;
		end else if (core_ok) begin
			next_power_status_field = `BMC_VST_BAT_OK;
		end else if (core_alive) begin
			next_power_status_field = `BMC_VST_BAT_NOFLASH;
		end else begin
			next_power_status_field = `BMC_VST_BAT_DYING;
		end
		// exhaustion reset after four crystal rising edges
		if (power_status_field == `BMC_VST_BAT_DYING) begin
			next_dying_count = dying_count;
			if (xtal && !xtal_prev && dying_count != `BMC_DYING_XTAL_TICKS) begin
				next_dying_count = dying_count + 3'h1;
			end
			next_cpu_reset = (next_dying_count == `BMC_DYING_XTAL_TICKS);
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mode                 <= BMC_MISSION;
			power_status_field   <= `BMC_VST_GOOD;
			wake_prev            <= 6'h00;
			wake_cause           <= 6'h00;
			display_only_request <= 1'b0;
			sleep_request        <= 1'b0;
			display_boost_select <= 2'h0;
			clock_gen_config     <= `BMC_CLOCK_GEN_RESET;
			ce_enable            <= 1'b0;
			irq                  <= 1'b0;
			xtal_prev            <= 1'b0;
			dying_count          <= 3'h0;
			cpu_reset            <= 1'b0;
			sleep_from_mission   <= 1'b0;
		end else begin
			mode                 <= next_mode;
			power_status_field   <= next_power_status_field;
			wake_prev            <= wake_now;
			wake_cause           <= next_wake_cause;
			display_only_request <= next_display_only_request;
			sleep_request        <= next_sleep_request;
			display_boost_select <= next_display_boost_select;
			clock_gen_config     <= next_clock_gen_config;
			ce_enable            <= next_ce_enable;
			irq                  <= next_irq;
			xtal_prev            <= xtal;
			dying_count          <= next_dying_count;
			cpu_reset            <= next_cpu_reset;
			sleep_from_mission   <= next_sleep_from_mission;
		end
	end

	// ------------------------------------------------------------
	// outputs and per-mode gating
	// ------------------------------------------------------------
	always_comb begin
		o_mode               = mode;
		o_on_battery         = (mode != BMC_MISSION);
		o_core_supply_enable = (mode == BMC_MISSION) || (mode == BMC_BROWNOUT);
		o_display_enable     = (mode != BMC_SLEEP);
		o_boost_enable       = (mode != BMC_SLEEP) && (display_boost_select == `BMC_BOOST_ON);
		if (mode == BMC_DISP_ONLY) begin
			o_pll_enable = (display_boost_select == `BMC_BOOST_ON);
		end else begin
			o_pll_enable = (mode != BMC_SLEEP);
		end
		o_clock_gen_config   = clock_gen_config;
		o_ce_enable          = ce_enable && o_core_supply_enable;
		bus.irq                = irq;
		bus.power_status_field = power_status_field;
		bus.wake_cause         = wake_cause;
		bus.cpu_run            = o_core_supply_enable;
		bus.cpu_reset          = cpu_reset;
	end
endmodule

// *** inc/bmc_cfg.svh ***
// Purpose: constants for the battery mode controller
// Assumes: 25 MHz core clock
// Notes:   offsets are byte addresses in the I/O RAM / SFR space
`ifndef BMC_CFG_SVH
`define BMC_CFG_SVH
`define BMC_ADDR_MODE_CTRL   16'h28B2
`define BMC_BIT_DISP_ONLY    6
`define BMC_BIT_SLEEP        7
`define BMC_ADDR_CE_CTRL     16'h2106
`define BMC_BIT_CE_ENABLE    0
`define BMC_ADDR_CLOCK_GEN   16'h2200
`define BMC_CLOCK_GEN_SLOW   8'h24
`define BMC_CLOCK_GEN_RESET  8'h3C
`define BMC_ADDR_DISP_BOOST  16'h2401
`define BMC_BOOST_MSB        7
`define BMC_BOOST_LSB        6
`define BMC_BOOST_ON         2'h2
`define BMC_ADDR_WAKE_STAT   16'h28B3
`define BMC_SFR_POWER_STAT   8'hF9
`define BMC_VST_GOOD         3'h0
`define BMC_VST_LOW          3'h1
`define BMC_VST_BAT_OK       3'h2
`define BMC_VST_BAT_NOFLASH  3'h3
`define BMC_VST_BAT_DYING    3'h5
`define BMC_DYING_XTAL_TICKS 3'h4
`define BMC_WAKE_BITS        6
`endif

// *** inc/bmc_pkg.sv ***
// Purpose: shared types for the battery mode controller
// Assumes: constants come from bmc_cfg.svh
// Notes:   one-hot mode codes
package bmc_pkg;
	typedef enum logic [3:0] {
		BMC_MISSION   = 4'h1,
		BMC_BROWNOUT  = 4'h2,
		BMC_DISP_ONLY = 4'h4,
		BMC_SLEEP     = 4'h8
	} bmc_mode_t;
endpackage

// *** inc/bmc_if.sv ***
// Purpose: link between the mode controller and the cpu-side end
// Assumes: single clock domain
// Notes:   cpu end issues I/O RAM writes, device end answers with status
`timescale 1ns/1ps
interface bmc_if;
	logic        wr_en;      // one-cycle write strobe
	logic [15:0] wr_addr;
	logic [7:0]  wr_data;
	logic        irq;        // one-cycle power change pulse
	logic [2:0]  power_status_field;
	logic [5:0]  wake_cause;
	logic        cpu_run;    // cpu powered and clocked
	logic        cpu_reset;  // supply-exhaustion reset
	modport dev (input wr_en, wr_addr, wr_data,
		output irq, power_status_field, wake_cause, cpu_run, cpu_reset);
	modport cpu (output wr_en, wr_addr, wr_data,
		input irq, power_status_field, wake_cause, cpu_run, cpu_reset);
endinterface

// *** hdl/bmc_sync.sv ***
// Purpose: two-flop synchroniser for a bus of asynchronous levels
// Assumes: inputs are quasi-static levels
// Notes:   only the second stage may be read
`timescale 1ns/1ps
module bmc_sync #(parameter int W = 1, parameter logic [W-1:0] RST = '0) (
	input  wire logic         i_mclk,
	input  wire logic         i_arst_n,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_sync;

	// shift chain
	always_comb begin
		next_meta = i_async;
		next_sync = meta;
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta   <= RST;                 // match the idle level of each pin
			o_sync <= RST;
		end else begin
			meta   <= next_meta;
			o_sync <= next_sync;
		end
	end
endmodule

// *** hdl/bmc_cpu_end.sv ***
// Purpose: cpu-side end: turns firmware requests into I/O RAM writes
// Assumes: requests are one-cycle pulses, one at a time
// Notes:   keeps the firmware duties on power loss and restore
`include "bmc_cfg.svh"
`timescale 1ns/1ps
module bmc_cpu_end
	import bmc_pkg::*;
(
	input  wire logic i_mclk,
	input  wire logic i_arst_n,
	input  wire logic i_req_disp_only,
	input  wire logic i_req_sleep,
	input  wire logic i_req_boost,
	bmc_if.cpu        bus,
	output logic      o_soft_reset,
	output logic [2:0] o_power_status_field
);
	// ------------------------------------------------------------
	// write sequencer
	// ------------------------------------------------------------
	logic [1:0]  pend_save;
	logic [1:0]  next_pend_save;
	logic        was_battery;
	logic        next_was_battery;
	logic        next_soft_reset;
	logic        on_battery;
	logic        next_wr_en;
	logic [15:0] next_wr_addr;
	logic [7:0]  next_wr_data;

	assign on_battery = bus.power_status_field[1] | bus.power_status_field[2];

	always_comb begin
		next_pend_save   = pend_save;
		next_was_battery = was_battery;
		next_soft_reset  = 1'b0;
		next_wr_en       = 1'b0;
		next_wr_addr     = bus.wr_addr;
		next_wr_data     = bus.wr_data;
		if (bus.irq && on_battery && !was_battery) begin
			next_pend_save   = 2'h3;
			next_was_battery = 1'b1;
		end else if (bus.irq && !on_battery && was_battery) begin
			next_was_battery = 1'b0;
			next_soft_reset  = 1'b1;
		end
		if (pend_save[0]) begin
			next_wr_en        = 1'b1;
			next_wr_addr      = `BMC_ADDR_CE_CTRL;
			next_wr_data      = 8'h00;
			next_pend_save[0] = 1'b0;
		end else if (pend_save[1]) begin
			next_wr_en        = 1'b1;
			next_wr_addr      = `BMC_ADDR_CLOCK_GEN;
			next_wr_data      = `BMC_CLOCK_GEN_SLOW;
			next_pend_save[1] = 1'b0;
		end else if (i_req_sleep || i_req_disp_only) begin
			next_wr_en   = 1'b1;
			next_wr_addr = `BMC_ADDR_MODE_CTRL;
			next_wr_data = 8'h00;
			next_wr_data[`BMC_BIT_SLEEP]     = i_req_sleep;
			next_wr_data[`BMC_BIT_DISP_ONLY] = i_req_disp_only;
		end else if (i_req_boost) begin
			next_wr_en   = 1'b1;
			next_wr_addr = `BMC_ADDR_DISP_BOOST;
			next_wr_data = 8'h00;
			next_wr_data[`BMC_BOOST_MSB:`BMC_BOOST_LSB] = `BMC_BOOST_ON;
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pend_save            <= 2'h0;
			was_battery          <= 1'b0;
			o_soft_reset         <= 1'b0;
			bus.wr_en            <= 1'b0;
			bus.wr_addr          <= 16'h0000;
			bus.wr_data          <= 8'h00;
			o_power_status_field <= `BMC_VST_GOOD;
		end else begin
			pend_save            <= next_pend_save;
			was_battery          <= next_was_battery;
			o_soft_reset         <= next_soft_reset;
			bus.wr_en            <= next_wr_en;
			bus.wr_addr          <= next_wr_addr;
			bus.wr_data          <= next_wr_data;
			o_power_status_field <= bus.power_status_field;
		end
	end
endmodule

// *** bench/bmc_checker.sv ***
// Purpose: assertions on the link between device end and cpu end
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   sees only the link signals
`timescale 1ns/1ps
module bmc_checker (
	input  wire logic        i_mclk,
	input  wire logic        i_arst_n,
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_addr,
	input  wire logic [7:0]  wr_data,
	input  wire logic        irq,
	input  wire logic [2:0]  power_status_field,
	input  wire logic [5:0]  wake_cause,
	input  wire logic        cpu_run,
	input  wire logic        cpu_reset
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);
	// battery status codes
	wire logic bat;
	assign bat = power_status_field[1] | power_status_field[2];

	status_code_a: assert property (
		!(power_status_field inside {3'h4, 3'h6, 3'h7})) else $error("illegal status code");
	dying_reset_a: assert property (
		$rose(cpu_reset) |-> $past(power_status_field) == 3'h5) else $error("reset without dying");
	dying_wait_a: assert property (
		$changed(power_status_field) && power_status_field == 3'h5 |-> !cpu_reset [*8])
		else $error("reset too early");
	ce_off_a: assert property (
		irq ##1 bat |-> ##[0:4] (wr_en && wr_addr == 16'h2106 && wr_data == 8'h00))
		else $error("engine not stopped");
	clock_slow_a: assert property (
		wr_en && wr_addr == 16'h2106 |=> wr_en && wr_addr == 16'h2200 && wr_data == 8'h24)
		else $error("clock not slowed");
	run_on_loss_a: assert property (
		irq ##1 bat |-> cpu_run [*4]) else $error("cpu halted on power loss");
	mission_run_a: assert property (
		irq ##1 power_status_field == 3'h0 |-> cpu_run) else $error("cpu off in mission");
	cpu_off_a: assert property (
		wr_en && wr_addr == 16'h28B2 && wr_data[7] |-> ##[1:3] !cpu_run)
		else $error("cpu still on in sleep");
	wake_cause_a: assert property (
		$changed(wake_cause) |-> !$past(cpu_run)) else $error("cause changed while awake");
endmodule

// *** bench/tb.sv ***
// Purpose: self-checking bench, both ends joined by the link
// Assumes: 25 MHz clock, inputs driven on the falling edge
// Notes:   wk bits 6..0 timer, button, pins a b c, serial, optical
`timescale 1ns/1ps
module tb;
	import bmc_pkg::*;
	logic       i_mclk, i_arst_n, s3v0, s2v8, c225, c20, pll, xtal, rq_d, rq_s, rq_b;
	logic       on_bat, pll_en, disp_en, boost_en, core_en, ce, soft_rst, saw_slp;
	logic [6:0] wk;
	logic [7:0] ckg;
	logic [2:0] psf_cpu;
	bmc_mode_t  mode;
	int         miscompares, n_checks, cycles, n_soft, seed, i, exp_mode;
	int         wake_q[$];
	bmc_if      link ();

	bmc_device bmc_device_inst (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
		.i_sys_above_3v0(s3v0), .i_sys_above_2v8(s2v8), .i_core_above_2v25(c225),
		.i_core_above_2v0(c20), .i_pll_locked(pll), .i_crystal_clock_32k(xtal),
		.i_wake_timer(wk[6]), .i_pushbutton_wake(wk[5]), .i_wake_pin_a(wk[4]),
		.i_wake_pin_b(wk[3]), .i_wake_pin_c(wk[2]), .i_serial_rx(wk[1]),
		.i_optical_receive(wk[0]), .bus(link.dev), .o_mode(mode), .o_on_battery(on_bat),
		.o_pll_enable(pll_en), .o_display_enable(disp_en), .o_boost_enable(boost_en),
		.o_core_supply_enable(core_en), .o_clock_gen_config(ckg), .o_ce_enable(ce));
	bmc_cpu_end bmc_cpu_end_inst (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
		.i_req_disp_only(rq_d), .i_req_sleep(rq_s), .i_req_boost(rq_b), .bus(link.cpu),
		.o_soft_reset(soft_rst), .o_power_status_field(psf_cpu));
	bmc_checker bmc_checker_inst (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .wr_en(link.wr_en),
		.wr_addr(link.wr_addr), .wr_data(link.wr_data), .irq(link.irq),
		.power_status_field(link.power_status_field), .wake_cause(link.wake_cause),
		.cpu_run(link.cpu_run), .cpu_reset(link.cpu_reset));

	// clock
	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end
	// watch pulses and modes, cut a hang short
	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (soft_rst === 1'b1)
			n_soft <= n_soft + 1;
		if (mode === BMC_SLEEP)
			saw_slp <= 1'b1;
		if (cycles == 20000) begin
			miscompares = miscompares + 1;
			give_verdict;
		end
	end
	// -------------------------------------------------------------------
	// tasks
	// -------------------------------------------------------------------
	task automatic give_verdict;
		if (miscompares == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge i_mclk);
	endtask
	task automatic wait_mode(input int e);
		int k;
		exp_mode = e;
		for (k = 0; k < 40 && mode !== bmc_mode_t'(exp_mode); k++)
			tick(1);
		chk("mode", 8'(exp_mode), {4'h0, mode});
	endtask
	task automatic req(input logic d, input logic s);
		rq_d = d;
		rq_s = s;
		tick(1);
		rq_d = 1'b0;
		rq_s = 1'b0;
	endtask
	task automatic xt(input int n);
		repeat (n) begin
			xtal = 1'b1;
			tick(3);
			xtal = 1'b0;
			tick(3);
		end
	endtask
	// -------------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------------
	initial begin
		seed = 32'hA390;
		{i_arst_n, rq_d, rq_s, rq_b, xtal, wk, saw_slp} = '0;
		{s3v0, s2v8, c225, c20, pll} = '1;
		{miscompares, n_checks, cycles, n_soft} = '0;
		tick(5);
		i_arst_n = 1'b1;
		tick(3);
		wait_mode(1);
		chk("clock gen", 8'h3C, ckg);
		s3v0 = 1'b0;
		tick(4);
		chk("status", 8'h01, {5'h0, link.power_status_field});
		chk("mode", 8'h01, {4'h0, mode});
		s2v8 = 1'b0;
		wait_mode(2);
		chk("on battery", 8'h01, {7'h0, on_bat});
		tick(6);
		chk("status", 8'h02, {5'h0, link.power_status_field});
		chk("cpu status", 8'h02, {5'h0, psf_cpu});
		chk("clock gen", 8'h24, ckg);
		chk("ce", 8'h00, {7'h0, ce});
		chk("pll", 8'h01, {7'h0, pll_en});
		c225 = 1'b0;
		tick(4);
		chk("status", 8'h03, {5'h0, link.power_status_field});
		c225 = 1'b1;
		// each wake source from display or sleep, noise while in brownout
		for (i = 6; i >= 0; i--) begin
			wk = 7'($random(seed));
			tick(4);
			wk = '0;
			tick(4);
			wait_mode(2);
			if ($random(seed) & 1) begin
				req(1'b1, 1'b0);
				wait_mode(4);
				chk("pll", 8'h00, {7'h0, pll_en});
				chk("display", 8'h01, {7'h0, disp_en});
				chk("boost", 8'h00, {7'h0, boost_en});
			end else begin
				req(1'b0, 1'b1);
				wait_mode(8);
				chk("display", 8'h00, {7'h0, disp_en});
			end
			chk("core", 8'h00, {7'h0, core_en});
			wk[i] = 1'b1;
			tick(4);
			wk[i] = 1'b0;
			wait_mode(2);
			chk("clock gen", 8'h3C, ckg);
			wake_q.push_back((i > 0) ? (1 << (i - 1)) : 1); // both receive pins share bit 0
			chk("wake cause", 8'(wake_q.pop_front()), {2'h0, link.wake_cause});
		end
		// boost on: display mode keeps the pll, sleep still stops it
		rq_b = 1'b1;
		tick(1);
		rq_b = 1'b0;
		tick(3);
		req(1'b1, 1'b0);
		wait_mode(4);
		chk("pll", 8'h01, {7'h0, pll_en});
		chk("boost", 8'h01, {7'h0, boost_en});
		wk[6] = 1'b1;
		tick(4);
		wk[6] = 1'b0;
		wait_mode(2);
		chk("wake cause", 8'h20, {2'h0, link.wake_cause});
		req(1'b1, 1'b1);
		wait_mode(8);
		chk("boost", 8'h00, {7'h0, boost_en});
		chk("pll", 8'h00, {7'h0, pll_en});
		wk[5] = 1'b1;
		tick(4);
		wk[5] = 1'b0;
		wait_mode(2);
		c225 = 1'b0;
		c20 = 1'b0;
		tick(4);
		chk("status", 8'h05, {5'h0, link.power_status_field});
		xt(3);
		chk("cpu reset", 8'h00, {7'h0, link.cpu_reset});
		xt(1);
		chk("cpu reset", 8'h01, {7'h0, link.cpu_reset});
		{c225, c20} = 2'b11;
		pll = 1'b0;
		s3v0 = 1'b1;
		s2v8 = 1'b1;
		tick(10);
		chk("mode", 8'h02, {4'h0, mode});
		pll = 1'b1;
		wait_mode(1);
		tick(3);
		chk("on battery", 8'h00, {7'h0, on_bat});
		chk("status", 8'h00, {5'h0, link.power_status_field});
		chk("soft resets", 8'h01, 8'(n_soft));
		req(1'b1, 1'b0);
		tick(6);
		chk("mode", 8'h01, {4'h0, mode});
		req(1'b0, 1'b1);
		tick(6);
		wait_mode(1);
		chk("saw sleep", 8'h01, {7'h0, saw_slp});
		give_verdict;
	end
endmodule
